// [sp_port_pkg.sv]
// Package for the data scratchpad RAM port: widths, field positions, structs.
package sp_port_pkg;

  localparam int unsigned VA_W           = 32;
  localparam int unsigned TAG_IDX_HI     = 19;
  localparam int unsigned TAG_IDX_LO     = 4;
  localparam int unsigned DATA_IDX_HI    = 19;
  localparam int unsigned DATA_IDX_LO    = 2;
  localparam int unsigned PA_TAG_HI      = 31;
  localparam int unsigned PA_TAG_LO      = 10;
  localparam int unsigned TAG_W          = 24;
  localparam int unsigned TAG_IDX_W      = TAG_IDX_HI - TAG_IDX_LO + 1;
  localparam int unsigned DATA_IDX_W     = DATA_IDX_HI - DATA_IDX_LO + 1;
  localparam int unsigned PA_TAG_W       = PA_TAG_HI - PA_TAG_LO + 1;
  localparam int unsigned WORD_W         = 32;
  localparam int unsigned BE_W           = 4;
  localparam int unsigned TAG_LOCK_BIT   = 1;
  localparam int unsigned TAG_VALID_BIT  = 0;
  localparam logic [1:0]  CMP_LOW_BITS   = 2'h0;
  localparam logic [TAG_W-1:0] TAG_LOW_RESET = 24'h000000;

  // Core-side request for one lookup/access cycle
  typedef struct packed {
    logic                  tag_read;
    logic                  tag_write;
    logic                  data_read;
    logic                  data_write;
    logic [VA_W-1:0]       vaddr;
    logic [VA_W-1:0]       paddr;
    logic [WORD_W-1:0]     wdata;
    logic [BE_W-1:0]       byte_en;
  } sp_req_t;

  // Array-side answer
  typedef struct packed {
    logic                  hit;
    logic                  stall;
    logic                  present;
    logic [TAG_W-1:0]      tag_read_word;
    logic [WORD_W-1:0]     read_word;
  } sp_rsp_t;

  // Pins toward the array
  typedef struct packed {
    logic [TAG_IDX_W-1:0]  sp_tag_index;
    logic                  sp_tag_read_strobe;
    logic                  sp_tag_write_strobe;
    logic [TAG_W-1:0]      sp_tag_compare_bus;
    logic [DATA_IDX_W-1:0] sp_data_index;
    logic [WORD_W-1:0]     sp_write_word;
    logic                  sp_data_read_strobe;
    logic                  sp_data_write_strobe;
    logic [BE_W-1:0]       sp_byte_enables;
  } sp_pins_t;

  typedef struct packed {
    logic [TAG_W-1:0]      tag_low_register;
    logic                  pending;
    logic                  pend_tag;
    logic                  pend_data;
  } sp_state_t;

endpackage

// [data_scratchpad_ram_port.sv]
// Core-side data scratchpad RAM port: unregistered strobes, tag and data paths.
`timescale 1ns/1ps
`default_nettype none
module data_scratchpad_ram_port
  import sp_port_pkg::*;
#(
  parameter int unsigned ADDR_W = VA_W
) (
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic      ce_i,
  input  wire sp_req_t   req_i,
  input  wire logic      tag_load_i,
  input  wire logic      tag_low_write_i,
  input  wire logic [TAG_W-1:0] tag_low_wdata_i,
  input  wire sp_rsp_t   rsp_i,
  output var sp_pins_t   pins_o,
  output logic           busy_o,
  output logic           rd_valid_o,
  output logic           hit_o,
  output logic [WORD_W-1:0] rd_word_o,
  output logic [TAG_W-1:0]  tag_low_o
);

  // Index slices and tag packing assume the package widths; refuse others
  if (ADDR_W != VA_W) begin
    $error("ADDR_W must equal VA_W");
  end
  if (TAG_W != PA_TAG_W + 2) begin
    $error("TAG_W must hold the page field and two flag bits");
  end
  if (BE_W * 8 != WORD_W) begin
    $error("BE_W must give one enable per byte lane");
  end
  if (TAG_IDX_LO < DATA_IDX_LO) begin
    $error("A tag line must not be smaller than a data word");
  end

  // Value after reset: tag-low cleared, nothing pending
  localparam sp_state_t ST_RESET = '{
    tag_low_register: TAG_LOW_RESET,
    pending:          1'b0,
    pend_tag:         1'b0,
    pend_data:        1'b0
  };

  // Tag array index: one stored tag per 16-byte line
  function automatic logic [TAG_IDX_W-1:0] tag_index_of(
    input logic [VA_W-1:0] va
  );
    return va[TAG_IDX_HI:TAG_IDX_LO];
  endfunction

  // Data array index: one word per entry
  function automatic logic [DATA_IDX_W-1:0] data_index_of(
    input logic [VA_W-1:0] va
  );
    return va[DATA_IDX_HI:DATA_IDX_LO];
  endfunction

  // Lookup operand: page bits with both flag positions cleared
  function automatic logic [TAG_W-1:0] compare_word_of(
    input logic [VA_W-1:0] pa
  );
    return {pa[PA_TAG_HI:PA_TAG_LO], CMP_LOW_BITS};
  endfunction

  // Page field of a tag word sits above the two flag bits
  function automatic logic [PA_TAG_W-1:0] page_of(
    input logic [TAG_W-1:0] tw
  );
    return tw[TAG_W-1:TAG_W-PA_TAG_W];
  endfunction

  // Stored tag layout: page bits, then lock, then valid
  function automatic logic [TAG_W-1:0] tag_word_of(
    input logic [PA_TAG_W-1:0] page,
    input logic                lock,
    input logic                valid
  );
    return {page, lock, valid};
  endfunction

  // Either read strobe makes a read that can stall
  function automatic logic wants_read(
    input logic tag_rd,
    input logic data_rd
  );
    return tag_rd | data_rd;
  endfunction

  sp_state_t               st_r;
  sp_state_t               st_nxt;
  logic                    req_tag_rd;
  logic                    req_tag_wr;
  logic                    req_data_rd;
  logic                    req_data_wr;
  logic                    do_tag_rd;
  logic                    do_data_rd;
  logic                    rd_req;
  logic                    rd_done;
  logic                    array_ready;
  logic                    writes_open;
  logic                    load_from_array;
  logic                    pend_set;
  logic                    pend_clr;
  logic [TAG_IDX_W-1:0]    tag_index;
  logic [DATA_IDX_W-1:0]   data_index;
  logic [TAG_W-1:0]        cmp_word;
  logic [TAG_W-1:0]        tag_bus;
  logic [PA_TAG_W-1:0]     tl_page;
  logic                    tl_lock;
  logic                    tl_valid;

  // Request bits and addresses go straight to the pins, no register stage
  assign req_tag_rd  = req_i.tag_read;
  assign req_tag_wr  = req_i.tag_write;
  assign req_data_rd = req_i.data_read;
  assign req_data_wr = req_i.data_write;
  assign tag_index   = tag_index_of(req_i.vaddr);
  assign data_index  = data_index_of(req_i.vaddr);
  assign cmp_word    = compare_word_of(req_i.paddr);

  // Tag-low fields as they go out on a tag write
  assign tl_page  = page_of(st_r.tag_low_register);
  assign tl_lock  = st_r.tag_low_register[TAG_LOCK_BIT];
  assign tl_valid = st_r.tag_low_register[TAG_VALID_BIT];

  // A stalled read keeps its strobes from the latched type, not from req_i,
  // so the core cannot change the kind of read in mid-stall
  assign do_tag_rd   = st_r.pending ? st_r.pend_tag  : req_tag_rd;
  assign do_data_rd  = st_r.pending ? st_r.pend_data : req_data_rd;
  assign rd_req      = wants_read(do_tag_rd, do_data_rd);
  // An absent array never completes; the core waits rather than take junk
  assign array_ready = rsp_i.present & ~rsp_i.stall;
  assign rd_done     = rd_req & array_ready;
  // Writes are refused from the cycle after a read stalls until it completes, so a stall cannot reorder them
  assign writes_open = ~st_r.pending;
  assign load_from_array = tag_load_i & rd_done & do_tag_rd;
  // Read tracking: latch the kind on a stall, drop it on completion
  assign pend_set    = rd_req & ~rd_done;
  assign pend_clr    = rd_done;

  // One bus carries both the lookup operand and the tag to be stored
  always_comb begin
    if (req_tag_wr) begin
      tag_bus = tag_word_of(tl_page, tl_lock, tl_valid);
    end else begin
      tag_bus = cmp_word;
    end
  end

  // Pins are combinational for single-cycle access; the array sits on a long
  // path, so only a mux or a gate stands between request and pin
  always_comb begin
    pins_o                      = '0;
    pins_o.sp_tag_index         = tag_index;
    pins_o.sp_data_index        = data_index;
    pins_o.sp_tag_read_strobe   = do_tag_rd;
    pins_o.sp_data_read_strobe  = do_data_rd;
    pins_o.sp_tag_compare_bus   = tag_bus;
    pins_o.sp_write_word        = req_i.wdata;
    pins_o.sp_byte_enables      = req_i.byte_en;
    if (writes_open) begin
      pins_o.sp_tag_write_strobe  = req_tag_wr;
      pins_o.sp_data_write_strobe = req_data_wr;
    end
  end

  always_comb begin
    st_nxt = st_r;
    if (pend_set) begin
      st_nxt.pending   = 1'b1;
      st_nxt.pend_tag  = do_tag_rd;
      st_nxt.pend_data = do_data_rd;
    end else if (pend_clr) begin
      st_nxt.pending   = 1'b0;
      st_nxt.pend_tag  = 1'b0;
      st_nxt.pend_data = 1'b0;
    end
    // Tag-low: a maintenance load beats a plain write in the same cycle
    if (load_from_array) begin
      st_nxt.tag_low_register = rsp_i.tag_read_word;
    end else if (tag_low_write_i) begin
      st_nxt.tag_low_register = tag_low_wdata_i;
    end
  end

  // Clock enable low freezes all state; the pins still follow req_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ST_RESET;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // Answers other than tag_low_o are unregistered so they land in the lookup cycle itself
  assign busy_o     = pend_set;
  assign rd_valid_o = rd_done & do_data_rd;
  assign hit_o      = rd_done & do_tag_rd & rsp_i.hit;
  assign rd_word_o  = rsp_i.read_word;
  assign tag_low_o  = st_r.tag_low_register;

endmodule
`default_nettype wire

// [data_scratchpad_ram_port_props.sv]
// Checker for the scratchpad port pins and completion flags.
`timescale 1ns/1ps
`default_nettype none
module sp_port_props
  import sp_port_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              ce_i,
  input wire sp_req_t           req_i,
  input wire sp_rsp_t           rsp_i,
  input wire sp_pins_t          pins_o,
  input wire logic              busy_o,
  input wire logic              hit_o,
  input wire logic              rd_valid_o,
  input wire logic [WORD_W-1:0] rd_word_o,
  input wire logic [TAG_W-1:0]  tag_low_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ti; pins_o.sp_tag_index == req_i.vaddr[19:4]; endproperty
  a_ti: assert property (p_ti) else $error("tag index");
  property p_di; pins_o.sp_data_index == req_i.vaddr[19:2]; endproperty
  a_di: assert property (p_di) else $error("data index");
  property p_cmp; !req_i.tag_write |-> pins_o.sp_tag_compare_bus == {req_i.paddr[31:10], 2'h0};
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare bus");
  property p_tw; req_i.tag_write |-> pins_o.sp_tag_compare_bus == tag_low_o; endproperty
  a_tw: assert property (p_tw) else $error("tag write bus");
  property p_ts; pins_o.sp_tag_write_strobe |-> req_i.tag_write; endproperty
  a_ts: assert property (p_ts) else $error("tag write strobe");
  property p_wd; pins_o.sp_write_word == req_i.wdata && pins_o.sp_byte_enables == req_i.byte_en;
  endproperty
  a_wd: assert property (p_wd) else $error("write word");
  property p_hold; busy_o && ce_i |=> pins_o.sp_data_read_strobe || pins_o.sp_tag_read_strobe;
  endproperty
  a_hold: assert property (p_hold) else $error("read dropped");
  property p_hit; hit_o |-> pins_o.sp_tag_read_strobe && rsp_i.hit && !rsp_i.stall; endproperty
  a_hit: assert property (p_hit) else $error("hit");
  property p_rv; rd_valid_o |-> !rsp_i.stall && rd_word_o == rsp_i.read_word; endproperty
  a_rv: assert property (p_rv) else $error("read valid");
  property p_st; rsp_i.stall && pins_o.sp_data_read_strobe |-> busy_o && !rd_valid_o; endproperty
  a_st: assert property (p_st) else $error("stall");
endmodule
bind data_scratchpad_ram_port sp_port_props u_props (.*);
`default_nettype wire

// [sp_array_model.sv]
// Behavioural scratchpad array: byte-lane store, one tag, optional one-cycle stall.
`timescale 1ns/1ps
`default_nettype none
module sp_array_model
  import sp_port_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     slow_i,
  input  wire sp_pins_t pins_i,
  output var sp_rsp_t   rsp_o
);
  logic [WORD_W-1:0] mem [16];
  logic [TAG_W-1:0]  tag_r;
  logic              waited_r;
  logic              rd;
  assign rd = pins_i.sp_data_read_strobe;
  always_ff @(posedge clk_i) begin
    waited_r <= rsp_o.stall;
    if (pins_i.sp_tag_write_strobe) tag_r <= pins_i.sp_tag_compare_bus;
    for (int b = 0; b < 4; b++)
      if (pins_i.sp_data_write_strobe && pins_i.sp_byte_enables[b])
        mem[pins_i.sp_data_index[3:0]][8*b+:8] <= pins_i.sp_write_word[8*b+:8];
  end
  always_comb begin
    rsp_o.present = 1'b1;
    rsp_o.stall = slow_i && !waited_r && (rd || pins_i.sp_tag_read_strobe);
    rsp_o.hit = pins_i.sp_tag_read_strobe && pins_i.sp_tag_compare_bus[23:2] == tag_r[23:2];
    // Unstrobed outputs show garbage so nothing leans on stale values
    rsp_o.tag_read_word = pins_i.sp_tag_read_strobe ? tag_r : ~tag_r;
    rsp_o.read_word = rd ? mem[pins_i.sp_data_index[3:0]] : ~mem[pins_i.sp_data_index[3:0]];
  end
endmodule
`default_nettype wire

// [data_scratchpad_ram_port_tb.sv]
// Self-checking bench: port plus array model against a word-array reference.
`timescale 1ns/1ps
`default_nettype none
module data_scratchpad_ram_port_tb;
  import sp_port_pkg::*;
  logic clk_i = 0, rst_i = 1, slow = 0, tag_load_i = 0, tag_low_write_i = 0, ce_i = 1;
  logic [TAG_W-1:0] tag_low_wdata_i = '0, tag_low_o, exp_tag;
  sp_req_t          req_i = '0;
  sp_rsp_t          rsp_i;
  sp_pins_t         pins_o;
  logic             busy_o, rd_valid_o, hit_o, seen_hit;
  logic [31:0]      rd_word_o, a, w, exp_mem [16];
  int               seed = 32811, fail_count = 0, n_compared = 0;
  always #5 clk_i = ~clk_i;
  data_scratchpad_ram_port dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i), .tag_load_i(tag_load_i),
    .tag_low_write_i(tag_low_write_i), .tag_low_wdata_i(tag_low_wdata_i), .rsp_i(rsp_i),
    .pins_o(pins_o), .busy_o(busy_o), .rd_valid_o(rd_valid_o), .hit_o(hit_o),
    .rd_word_o(rd_word_o), .tag_low_o(tag_low_o));
  sp_array_model arr (.clk_i(clk_i), .slow_i(slow), .pins_i(pins_o), .rsp_o(rsp_i));
  task automatic chk(string n, logic [31:0] e, s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One request; held while the array stalls, never longer than three cycles
  task automatic acc(logic [3:0] k, logic [3:0] be);
    req_i <= '{k[3], k[2], k[1], k[0], a, a, w, be};
    #1;
    chk("busy", (k[3] | k[1]) & slow, busy_o);
    repeat (3) if (busy_o) begin @(posedge clk_i); #1; end
    chk("busy end", 0, busy_o);
    seen_hit = hit_o;
    if (k[1]) chk("read_word", exp_mem[a[5:2]], rd_word_o);
    chk("rd_valid", k[1], rd_valid_o);
    if (k[0]) for (int b = 0; b < 4; b++) if (be[b]) exp_mem[a[5:2]][8*b+:8] = w[8*b+:8];
    @(posedge clk_i);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    #1 chk("tag_low reset", TAG_LOW_RESET, tag_low_o);
    @(posedge clk_i);
    a = $random(seed);
    exp_tag = {a[31:10], 2'h3};
    tag_low_wdata_i <= exp_tag;
    tag_low_write_i <= 1;
    @(posedge clk_i);
    tag_low_write_i <= 0;
    acc(4'b0100, 4'h0);
    tag_low_wdata_i <= 24'h000001;
    tag_low_write_i <= 1;
    acc(4'b1000, 4'h0);
    chk("hit", 1, seen_hit);
    tag_low_write_i <= 0;
    tag_load_i <= 1;
    a[10] = ~a[10];
    acc(4'b1000, 4'h0);
    chk("miss", 0, seen_hit);
    tag_load_i <= 0;
    #1 chk("tag_low load", exp_tag, tag_low_o);
    @(posedge clk_i);
    ce_i <= 0;
    tag_low_wdata_i <= 24'h5A5A5A;
    tag_low_write_i <= 1;
    @(posedge clk_i);
    #1 chk("ce hold", exp_tag, tag_low_o);
    @(posedge clk_i);
    ce_i <= 1;
    @(posedge clk_i);
    #1 chk("ce resume", 24'h5A5A5A, tag_low_o);
    @(posedge clk_i);
    tag_low_write_i <= 0;
    rst_i <= 1;
    @(posedge clk_i);
    rst_i <= 0;
    #1 chk("tag_low rerst", TAG_LOW_RESET, tag_low_o);
    @(posedge clk_i);
    $display("test tag done");
    for (int i = 0; i < 60; i++) begin
      a = $random(seed);
      w = $random(seed);
      if (i < 16) a[5:2] = i[3:0];
      slow <= a[7];
      acc(i < 16 ? 4'b0001 : {2'b00, a[8], !a[8]}, i < 16 ? 4'hF : w[3:0]);
    end
    $display("test data done");
    conclude();
  end
  initial begin
    #20000;
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
